// File: rtl/usb_ep_pkg.sv
package usb_ep_pkg;

  // ----------------------------------------------------------------
  // Register map on the processor I/O space
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_ADDR_BASE = 8'h44; // endpoint 0, then 1, 2
  localparam logic [7:0] CNT_ADDR_BASE  = 8'h4A; // endpoint 0, then 1, 2
  localparam logic [7:0] BUF1_FIRST     = 8'h58;
  localparam logic [7:0] BUF1_LAST      = 8'h5F;
  localparam logic [7:0] BUF2_FIRST     = 8'h60;
  localparam logic [7:0] BUF2_LAST      = 8'h67;
  localparam int         NUM_EP         = 3;

  // ----------------------------------------------------------------
  // Field positions, reset values and limits
  // ----------------------------------------------------------------
  localparam int         STALL_BIT  = 7;
  localparam int         ACKD_BIT   = 4;
  localparam int         TOG_BIT    = 7;
  localparam int         DVAL_BIT   = 6;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET  = 8'h00;
  localparam logic [4:0] RX_MAX_CNT = 5'h0A; // payload plus two CRC bytes
  localparam logic [4:0] STATUS_CNT = 5'h02; // zero payload plus CRC
  localparam logic [3:0] BUF_BYTES  = 4'h8;

  // ----------------------------------------------------------------
  // Endpoint mode encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] M_DISABLE   = 4'h0;
  localparam logic [3:0] M_NAK_INOUT = 4'h1;
  localparam logic [3:0] M_STAT_OUT  = 4'h2;
  localparam logic [3:0] M_STALL_IO  = 4'h3;
  localparam logic [3:0] M_STAT_IN   = 4'h6;
  localparam logic [3:0] M_ACKOUT_SI = 4'hB;
  localparam logic [3:0] M_ACKIN_SO  = 4'hF;
  localparam logic [3:0] M_NAK_OUT   = 4'h8;
  localparam logic [3:0] M_ACK_OUT   = 4'h9;
  localparam logic [3:0] M_NAK_IN    = 4'hC;
  localparam logic [3:0] M_ACK_IN    = 4'hD;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PID_SETUP = 2'h0,
    PID_IN    = 2'h1,
    PID_OUT   = 2'h2
  } pid_t;

  typedef enum logic [2:0] {
    RESP_NONE  = 3'h0,
    RESP_ACK   = 3'h1,
    RESP_NAK   = 3'h2,
    RESP_STALL = 3'h3,
    RESP_DATA  = 3'h4
  } resp_code_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } state_t;

  typedef struct packed {
    pid_t       pid;
    logic [1:0] ep;
    logic [4:0] count;  // OUT/SETUP: payload bytes plus two
    logic       dval;
    logic       toggle;
  } xact_t;

  typedef struct packed {
    logic [1:0] ep;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       empty;  // zero-length packet marker
  } tx_item_t;

endpackage

// File: rtl/usb_endpoint_mode_responder.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Small shift-register buffer, head entry drives the output data directly
// ------------------------------------------------------------------
module usb_ep_skid_buf #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] fill_reg;
  logic [$clog2(DEPTH+1)-1:0] fill_next;
  logic                       valid_reg;
  wire  push = in_valid && in_ready;
  wire  pop  = out_valid && out_ready;

  // Full straight from the fill level; empty from its own flop
  assign in_ready  = (fill_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = valid_reg;  // Flop, so the port never glitches
  assign out_data  = mem_reg[0];
  assign fill_next = fill_reg + {{($clog2(DEPTH+1)-1){1'b0}}, push}
                              - {{($clog2(DEPTH+1)-1){1'b0}}, pop};

  // Level counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fill_reg  <= '0;
      valid_reg <= 1'b0;
    end else begin
      fill_reg  <= fill_next;
      valid_reg <= (fill_next != '0);
    end
  end

  // Entries shift toward the head on a pop; data needs no reset
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      wire [$clog2(DEPTH+1)-1:0] idx = g[$clog2(DEPTH+1)-1:0];
      always_ff @(posedge clk_sys) begin
        if (pop) begin
          if (push && (idx + 1'b1 == fill_reg)) begin
            mem_reg[g] <= in_data;
          end else if (g < DEPTH - 1) begin
            mem_reg[g] <= mem_reg[(g < DEPTH - 1) ? g + 1 : g];
          end
        end else if (push && (idx == fill_reg)) begin
          mem_reg[g] <= in_data;
        end
      end
    end
  endgenerate
endmodule

// Summary of operation
// - Endpoint one buffer: eight bytes at I/O addresses 0x58 to 0x5F.
// - Endpoint two buffer: eight bytes at I/O addresses 0x60 to 0x67.
// - Buffers hold IN and OUT payloads alike; no reset value.
// - Buffers are reached through the processor I/O port and by received OUT bytes and IN transmit.
// - Mode value sits in bits 3..0 of each mode register.
// - Mode 0000 ignores SETUP, IN and OUT on any endpoint.
// - Control modes ACK valid SETUP; mode 0001 NAKs IN and OUT.
// - Mode 0010 stalls IN and status-checks OUT.
// - Mode 0011 stalls every IN and every valid OUT on the control endpoint.
// - Mode 0110 stalls OUT and sends zero-length data on IN.
// - Mode 1011 ACKs OUT and sends zero-length data on IN.
// - Mode 1111 sends the counted bytes on IN, status-checks OUT.
// - Status check ACKs only zero-length DATA1, otherwise stalls.
// - Counted transmit sends the count field's bytes, at most eight.
// - Data mode 1000 NAKs OUT, ignores SETUP and IN.
// - Mode 1001, stall clear: ACK OUT, then mode becomes 1000.
// - Mode 1001, stall set: STALL OUT, ignore the rest.
// - Data mode 1100 NAKs IN, ignores SETUP and OUT.
// - Mode 1101, stall clear: send data; after host ACK mode 1100.
// - Mode 1101, stall set: STALL IN, ignore SETUP and OUT.
// - Modes 0100, 0101, 0111, 1010, 1110 ignore every token.
// - Received OUT or SETUP records payload bytes plus two as count.
// - Data endpoint bit 7 is the stall flag for the ACK modes.
module usb_endpoint_mode_responder
  import usb_ep_pkg::*;
#(
  parameter int TX_DEPTH = 2
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Processor I/O port
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // Decoded transactions from the serial interface engine front end
  input  wire logic       xact_valid,
  input  wire xact_t      xact,
  input  wire logic       rx_valid,
  input  wire rx_byte_t   rx,
  input  wire logic       hs_valid,
  input  wire logic       hs_ack,
  // Handshake answer towards the host
  output logic            resp_valid,
  output resp_code_t      resp_code,
  output logic            resp_toggle,
  // Transmit data stream
  output logic            tx_valid,
  output tx_item_t        tx_item,
  input  wire logic       tx_ready
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  mode_reg [NUM_EP];
  logic [7:0]  cnt_reg  [NUM_EP];
  logic [7:0]  buf_mem  [16];          // no reset: contents undefined
  state_t      state_reg, state_next;
  logic [1:0]  tx_ep_reg;
  logic [3:0]  tx_len_reg, tx_idx_reg;
  logic [3:0]  rx_idx_reg;
  logic [7:0]  rdata_reg;
  logic        resp_valid_reg, resp_toggle_reg;
  resp_code_t  resp_code_reg;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [3:0] buf_index(input logic       ep2,
                                           input logic [2:0] off);
    return {ep2, off};
  endfunction

  wire hit_buf1 = in_range(io_addr, BUF1_FIRST, BUF1_LAST);
  wire hit_buf2 = in_range(io_addr, BUF2_FIRST, BUF2_LAST);
  wire [3:0] cpu_buf_idx = buf_index(hit_buf2, io_addr[2:0]);
  wire [1:0] mode_sel = 2'(io_addr - MODE_ADDR_BASE);
  wire [1:0] cnt_sel  = 2'(io_addr - CNT_ADDR_BASE);
  wire hit_mode = in_range(io_addr, MODE_ADDR_BASE, MODE_ADDR_BASE + 8'h02);
  wire hit_cnt  = in_range(io_addr, CNT_ADDR_BASE, CNT_ADDR_BASE + 8'h02);

  // ----------------------------------------------------------------
  // Token decision for the transaction now presented
  // ----------------------------------------------------------------
  wire [7:0]  cur_mode_f = mode_reg[xact.ep];
  wire [3:0]  cur_mode   = cur_mode_f[3:0];
  wire        is_ctrl    = (xact.ep == 2'h0);
  wire        cur_stall  = !is_ctrl && cur_mode_f[STALL_BIT];
  wire        rx_ok      = xact.dval && (xact.count <= RX_MAX_CNT);
  wire        good_stat  = (xact.count == STATUS_CNT) && xact.toggle;
  wire [3:0]  cur_cnt    = cnt_reg[xact.ep][3:0];
  wire [3:0]  counted    = (cur_cnt > BUF_BYTES) ? BUF_BYTES : cur_cnt;

  resp_code_t d_code;
  logic       d_mode_we, d_cnt_we, d_ackd, d_tx;
  logic [3:0] d_mode, d_len;

  // Unlisted codes fall to the default and are ignored
  always_comb begin
    d_code    = RESP_NONE;
    d_mode_we = 1'b0;
    d_mode    = cur_mode;
    d_cnt_we  = 1'b0;
    d_ackd    = 1'b0;
    d_tx      = 1'b0;
    d_len     = 4'h0;
    if (is_ctrl && (cur_mode inside {M_NAK_INOUT, M_STAT_OUT, M_STALL_IO,
                                     M_STAT_IN, M_ACKOUT_SI, M_ACKIN_SO}))
    begin
      unique case (xact.pid)
        PID_SETUP: begin
          if (rx_ok) begin
            d_code    = RESP_ACK;
            d_mode_we = 1'b1;
            d_mode    = M_NAK_INOUT;
            d_cnt_we  = 1'b1;
            d_ackd    = 1'b1;
          end
        end
        PID_IN: begin
          unique case (cur_mode)
            M_NAK_INOUT: d_code = RESP_NAK;
            M_STAT_OUT: begin
              d_code    = RESP_STALL;
              d_mode_we = 1'b1;
              d_mode    = M_STALL_IO;
            end
            M_STALL_IO: d_code = RESP_STALL;
            M_STAT_IN, M_ACKOUT_SI: begin
              d_code = RESP_DATA;
              d_tx   = 1'b1;
            end
            default: begin
              d_code = RESP_DATA;
              d_tx   = 1'b1;
              d_len  = counted;
            end
          endcase
        end
        default: begin
          if (rx_ok) begin
            unique case (cur_mode)
              M_NAK_INOUT: d_code = RESP_NAK;
              M_STALL_IO, M_STAT_IN: d_code = RESP_STALL;
              M_ACKOUT_SI: begin
                d_code   = RESP_ACK;
                d_cnt_we = 1'b1;
                d_ackd   = 1'b1;
              end
              default: begin
                d_mode_we = 1'b1;
                if (good_stat) begin
                  d_code   = RESP_ACK;
                  d_mode   = M_STAT_OUT;
                  d_cnt_we = 1'b1;
                  d_ackd   = 1'b1;
                end else begin
                  d_code = RESP_STALL;
                  d_mode = M_STALL_IO;
                end
              end
            endcase
          end
        end
      endcase
    end else if (!is_ctrl) begin
      // Data endpoints answer only the token their mode names
      if (xact.pid == PID_OUT && rx_ok) begin
        if (cur_mode == M_NAK_OUT) begin
          d_code = RESP_NAK;
        end else if (cur_mode == M_ACK_OUT && cur_stall) begin
          d_code = RESP_STALL;
        end else if (cur_mode == M_ACK_OUT) begin
          d_code    = RESP_ACK;
          d_mode_we = 1'b1;
          d_mode    = M_NAK_OUT;
          d_cnt_we  = 1'b1;
          d_ackd    = 1'b1;
        end
      end else if (xact.pid == PID_IN) begin
        if (cur_mode == M_NAK_IN) begin
          d_code = RESP_NAK;
        end else if (cur_mode == M_ACK_IN && cur_stall) begin
          d_code = RESP_STALL;
        end else if (cur_mode == M_ACK_IN) begin
          d_code = RESP_DATA;
          d_tx   = 1'b1;
          d_len  = counted;
        end
      end
    end
    // Mode 0000 and the reserved codes leave everything at rest
  end

  // ----------------------------------------------------------------
  // Sequencer: decide, stream the payload, wait for the host
  // ----------------------------------------------------------------
  wire take_xact = xact_valid && (state_reg == ST_IDLE);
  wire sent_last;
  wire push_ok;
  wire hs_done = hs_valid && (state_reg == ST_WAIT);
  wire [7:0] tx_mode_f = mode_reg[tx_ep_reg];

  // Host handshake seen after our data
  wire        hs_mode_we = hs_done && hs_ack &&
                           (tx_mode_f[3:0] inside {M_ACKIN_SO, M_ACKOUT_SI,
                                                   M_ACK_IN});
  wire [3:0]  hs_mode = (tx_mode_f[3:0] == M_ACKIN_SO)  ? M_NAK_INOUT :
                        (tx_mode_f[3:0] == M_ACKOUT_SI) ? M_STALL_IO :
                                                          M_NAK_IN;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (take_xact && d_tx) state_next = ST_SEND;
      ST_SEND: if (sent_last) state_next = ST_WAIT;
      ST_WAIT: if (hs_valid) state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Transmit cursor over the buffer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_ep_reg  <= 2'h0;
      tx_len_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
    end else if (take_xact && d_tx) begin
      tx_ep_reg  <= xact.ep;
      tx_len_reg <= d_len;
      tx_idx_reg <= 4'h0;
    end else if (push_ok) begin
      tx_idx_reg <= tx_idx_reg + 4'h1;
    end
  end

  // Stall on a full buffer so no byte is dropped
  tx_item_t  push_item;
  logic      push_ready;
  wire       push_valid = (state_reg == ST_SEND);
  assign push_ok   = push_valid && push_ready;
  assign push_item.data  = buf_mem[buf_index(tx_ep_reg[1], tx_idx_reg[2:0])];
  assign push_item.empty = (tx_len_reg == 4'h0);
  assign push_item.last  = push_item.empty ||
                           (tx_idx_reg + 4'h1 == tx_len_reg);
  assign sent_last = push_ok && push_item.last;

  usb_ep_skid_buf #(
    .WIDTH ($bits(tx_item_t)),
    .DEPTH (TX_DEPTH)
  ) u_tx_buf (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (push_valid),
    .in_data   (push_item),
    .in_ready  (push_ready),
    .out_valid (tx_valid),
    .out_data  (tx_item),
    .out_ready (tx_ready)
  );

  // Handshake answer, one-cycle pulse from flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid_reg  <= 1'b0;
      resp_code_reg   <= RESP_NONE;
      resp_toggle_reg <= 1'b0;
    end else begin
      resp_valid_reg  <= take_xact && (d_code != RESP_NONE);
      resp_code_reg   <= take_xact ? d_code : RESP_NONE;
      resp_toggle_reg <= cnt_reg[xact.ep][TOG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Mode and count registers, hardware update beats a CPU write
  // ----------------------------------------------------------------
  genvar e;
  generate
    for (e = 0; e < NUM_EP; e++) begin : g_ep
      wire is_me   = take_xact && (xact.ep == 2'(e));
      wire hw_mode = (is_me && d_mode_we) ||
                     (hs_mode_we && tx_ep_reg == 2'(e));
      wire [3:0] hw_val = (is_me && d_mode_we) ? d_mode : hs_mode;
      wire hw_ackd = (is_me && d_ackd) ||
                     (hs_done && hs_ack && tx_ep_reg == 2'(e));
      wire cpu_mode = io_wr && hit_mode && (mode_sel == 2'(e));
      wire cpu_cnt  = io_wr && hit_cnt && (cnt_sel == 2'(e));
      // Endpoint 0 write clears the upper nibble; others take bits 7..5 and clear bit 4
      wire [7:0] cpu_val = (e == 0) ? {4'h0, io_wdata[3:0]} :
                           {io_wdata[7:5], 1'b0, io_wdata[3:0]};
      wire [7:0] base = cpu_mode ? cpu_val : mode_reg[e];

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          mode_reg[e] <= MODE_RESET;
        end else begin
          mode_reg[e] <= {base[7:5], base[ACKD_BIT] | hw_ackd,
                          hw_mode ? hw_val : base[3:0]};
        end
      end

      // Received count keeps reserved bits untouched
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cnt_reg[e] <= CNT_RESET;
        end else if (is_me && d_cnt_we) begin
          cnt_reg[e] <= {xact.toggle, 1'b1, cnt_reg[e][5:4],
                         xact.count[3:0]};
        end else if (cpu_cnt) begin
          cnt_reg[e] <= io_wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Endpoint buffers: received bytes land only in ACK-OUT mode
  // ----------------------------------------------------------------
  wire [7:0] rx_mode_f = mode_reg[rx.ep];
  wire rx_wr = rx_valid && (rx.ep != 2'h0) && (rx_idx_reg < BUF_BYTES) &&
               (rx_mode_f[3:0] == M_ACK_OUT) && !rx_mode_f[STALL_BIT];
  wire cpu_buf_wr = io_wr && (hit_buf1 || hit_buf2);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_idx_reg <= 4'h0;
    end else if (xact_valid) begin
      rx_idx_reg <= 4'h0;
    end else if (rx_valid) begin
      rx_idx_reg <= rx_idx_reg + 4'h1;
    end
  end

  // Engine writes take the port when both collide
  always_ff @(posedge clk_sys) begin
    if (rx_wr) begin
      buf_mem[buf_index(rx.ep[1], rx_idx_reg[2:0])] <= rx.data;
    end else if (cpu_buf_wr) begin
      buf_mem[cpu_buf_idx] <= io_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data, unmapped addresses read as zero
  // ----------------------------------------------------------------
  wire [7:0] rd_mux = (hit_buf1 || hit_buf2) ? buf_mem[cpu_buf_idx] :
                      hit_mode ? mode_reg[mode_sel] :
                      hit_cnt  ? cnt_reg[cnt_sel] : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (io_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign io_rdata    = rdata_reg;
  assign resp_valid  = resp_valid_reg;
  assign resp_code   = resp_code_reg;
  assign resp_toggle = resp_toggle_reg;

endmodule

// File: dv/usb_ep_resp_props.sv
`timescale 1ns/1ps
// ----
// Port-level checks on answers and transmit stream
// ----
module usb_ep_resp_props
  import usb_ep_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // Tokens in
  input wire logic       xact_valid,
  input wire xact_t      xact,
  // Answers and data out
  input wire logic       resp_valid,
  input wire resp_code_t resp_code,
  input wire logic       tx_valid,
  input wire tx_item_t   tx_item,
  input wire logic       tx_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_resp_has_cause: assert property (
    resp_valid |-> $past(xact_valid)) else $error("answer without token");
  a_setup_acked: assert property (
    resp_valid && $past(xact.pid) == PID_SETUP |-> resp_code == RESP_ACK)
    else $error("setup not acked");
  a_in_never_ack: assert property (
    resp_valid && $past(xact.pid) == PID_IN |-> resp_code != RESP_ACK)
    else $error("IN token acked");
  a_data_for_in: assert property (
    resp_valid && resp_code == RESP_DATA |-> $past(xact.pid) == PID_IN)
    else $error("data sent without IN");
  a_out_handshake: assert property (
    resp_valid && $past(xact.pid) == PID_OUT
    |-> resp_code inside {RESP_ACK, RESP_NAK, RESP_STALL})
    else $error("OUT answer not a handshake");
  a_bad_pkt_quiet: assert property (
    xact_valid && xact.pid != PID_IN && (xact.count > 5'h0A || !xact.dval)
    |=> !resp_valid) else $error("bad packet answered");
  a_data_follows: assert property (
    resp_valid && resp_code == RESP_DATA |-> ##[0:4] tx_valid)
    else $error("data answer without items");
  a_tx_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_item))
    else $error("stalled item changed");
  a_zlp_single: assert property (
    tx_valid && tx_item.empty |-> tx_item.last)
    else $error("zero-length item not last");
endmodule

bind usb_endpoint_mode_responder usb_ep_resp_props u_props (.*);

// File: dv/usb_host_model.sv
`timescale 1ns/1ps
// ----
// Host side: drains IN data, then hands back a handshake
// ----
module usb_host_model
  import usb_ep_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst_b,
  // Device transmit stream
  input  wire logic     tx_valid,
  input  wire tx_item_t tx_item,
  output logic          tx_ready,
  // Handshake back to the device
  output logic          hs_valid,
  output logic          hs_ack,
  // Test controls
  input  wire logic     ack_en,
  input  wire logic     slow
);
  logic [7:0] got [0:7];
  logic       zl = 1'b0;
  logic       fire;
  int         nb = 0;
  int         sd = 77;
  // Take items on the edge, answer just after it
  always @(posedge clk_sys) begin
    fire = tx_valid && tx_ready;
    if (fire && !tx_item.empty && nb < 8) got[nb] = tx_item.data;
    if (fire && !tx_item.empty) nb++;
    if (fire && tx_item.empty) zl = 1'b1;
    fire = fire && tx_item.last;
    #1;
    tx_ready = rst_b && (!slow || 1'($random(sd)));
    hs_valid = rst_b && fire;
    hs_ack   = fire ? ack_en : 1'($random(sd)); // Noise outside the phase
  end
endmodule

// File: dv/tb_usb_endpoint_mode_responder.sv
`timescale 1ns/1ps
module tb_usb_endpoint_mode_responder;
  import usb_ep_pkg::*;
  logic clk_sys, rst_b, io_wr, io_rd, xact_valid, rx_valid, st, tg;
  logic resp_valid, resp_toggle, tx_valid, tx_ready, hs_valid, hs_ack;
  logic ack_en, slow;
  logic [7:0] io_addr, io_wdata, io_rdata, rd, r8;
  logic [7:0] bimg [0:15];
  xact_t      xact, x;
  rx_byte_t   rx;
  resp_code_t resp_code, c;
  tx_item_t   tx_item;
  int         errors, num_checks, seed, n, r;

  usb_endpoint_mode_responder #(.TX_DEPTH(2)) uut (.*);
  usb_host_model host (.*);

  // ----
  // Clock and shared tasks
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic iow(input logic [7:0] a, input logic [7:0] d);
    io_addr = a; io_wdata = d; io_wr = 1'b1; tick(); io_wr = 1'b0; tick();
  endtask
  task automatic ior(input logic [7:0] a);
    io_addr = a; io_rd = 1'b1; tick(); io_rd = 1'b0; rd = io_rdata; tick();
  endtask
  // Token out, answer caught, IN data drained up to the handshake
  task automatic tok(input xact_t t);
    int k;
    xact = t; xact_valid = 1'b1; c = RESP_NONE; host.nb = 0; host.zl = 0;
    tick();
    xact_valid = 1'b0;
    if (resp_valid === 1'b1) c = resp_code;
    tg = resp_toggle;
    tick();
    if (c == RESP_DATA) begin
      k = 0;
      do begin @(posedge clk_sys); k++; end
      while (hs_valid !== 1'b1 && k < 60);
      if (hs_valid !== 1'b1) begin
        chk({7'h0, hs_valid}, 8'h01);
        conclude();
      end
      #1; tick();
    end
  endtask
  // Handshake expected for a mode, stall flag and token
  function automatic resp_code_t exp_r(logic [3:0] m, logic s, xact_t t);
    if (t.pid != PID_IN && (t.count > RX_MAX_CNT || !t.dval))
      return RESP_NONE;
    if (t.ep == 2'h0) begin
      if (!(m inside {4'h1, 4'h2, 4'h3, 4'h6, 4'hB, 4'hF}))
        return RESP_NONE;
      if (t.pid == PID_SETUP) return RESP_ACK;
      if (t.pid == PID_IN) return m == 4'h1 ? RESP_NAK
        : m < 4'h4 ? RESP_STALL : RESP_DATA;
      if (m == 4'h1) return RESP_NAK;
      if (m == 4'hB) return RESP_ACK;
      if (m == 4'h3 || m == 4'h6) return RESP_STALL;
      return (t.count == STATUS_CNT && t.toggle) ? RESP_ACK
        : RESP_STALL;
    end
    if (t.pid == PID_OUT && m[3:1] == 3'h4)
      return m[0] ? (s ? RESP_STALL : RESP_ACK) : RESP_NAK;
    if (t.pid == PID_IN && m[3:1] == 3'h6)
      return m[0] ? (s ? RESP_STALL : RESP_DATA) : RESP_NAK;
    return RESP_NONE;
  endfunction

  // ----
  // Main sequence
  // ----
  initial begin
    seed = 3265; errors = 0; num_checks = 0; rst_b = 1'b0; io_wr = 1'b0;
    io_rd = 1'b0; io_addr = '0; io_wdata = '0; xact_valid = 1'b0;
    xact = '0; rx_valid = 1'b0; rx = '0; ack_en = 1'b0; slow = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    tick();
    for (int i = 0; i < 3; i++) begin
      ior(MODE_ADDR_BASE + 8'(i)); chk(rd, MODE_RESET);
      ior(CNT_ADDR_BASE + 8'(i)); chk(rd, CNT_RESET);
    end
    for (int i = 0; i < 16; i++) begin
      bimg[i] = 8'($random(seed)); iow(BUF1_FIRST + 8'(i), bimg[i]);
    end
    for (int i = 0; i < 16; i++) begin
      ior(BUF1_FIRST + 8'(i)); chk(rd, bimg[i]);
    end
    iow(8'h68, 8'hA5); ior(8'h68); chk(rd, 8'h00);
    // Every mode against every token, host never ACKing data
    repeat (2) for (int e = 0; e < 3; e++) for (int m = 0; m < 16; m++)
      for (int p = 0; p < 3; p++) begin
        r = $random(seed);
        st = (m == 9 || m == 13) && r[12];
        iow(MODE_ADDR_BASE + 8'(e), {st, 3'h0, 4'(m)});
        x = '{pid_t'(p), 2'(e), r[0] ? 5'h02 : 5'(3 + r[7:4] % 10),
              r[9] | r[8], r[10] | r[11]};
        tok(x);
        chk(8'(c), 8'(exp_r(4'(m), st, x)));
        if (c == RESP_DATA && (m == 6 || m == 11))
          chk({7'h0, host.zl}, 8'h01);
      end
    // Counted IN with a stalling host that ACKs, then OUT stored
    slow = 1'b1; ack_en = 1'b1;
    for (int e = 1; e < 3; e++) begin
      n = $unsigned($random(seed)) % 9;
      r8 = {1'(n), 3'h0, 4'(n)};
      iow(CNT_ADDR_BASE + 8'(e), r8); iow(MODE_ADDR_BASE + 8'(e), 8'h0D);
      tok('{PID_IN, 2'(e), 5'h00, 1'b0, 1'b0});
      chk(8'(c), 8'(RESP_DATA));
      chk({7'h0, tg}, {7'h0, r8[7]});
      chk(8'(host.nb), 8'(n));
      for (int i = 0; i < n; i++) chk(host.got[i], bimg[8*e-8+i]);
      ior(MODE_ADDR_BASE + 8'(e)); chk(rd, 8'h1C);
      iow(MODE_ADDR_BASE + 8'(e), 8'h89);
      tok('{PID_OUT, 2'(e), 5'h02, 1'b1, 1'b1});
      chk(8'(c), 8'(RESP_STALL));
      ior(MODE_ADDR_BASE + 8'(e)); chk(rd, 8'h89);
      iow(MODE_ADDR_BASE + 8'(e), 8'h09);
      for (int i = 0; i < n; i++) begin
        bimg[i] = 8'($random(seed)); rx = '{2'(e), bimg[i]}; rx_valid = 1'b1;
        tick();
      end
      rx_valid = 1'b0;
      r8 = {~r8[7], 3'h4, 4'(n + 2)};
      tok('{PID_OUT, 2'(e), 5'(n + 2), 1'b1, r8[7]});
      chk(8'(c), 8'(RESP_ACK));
      ior(MODE_ADDR_BASE + 8'(e)); chk(rd, 8'h18);
      ior(CNT_ADDR_BASE + 8'(e)); chk(rd, r8);
      for (int i = 0; i < n; i++) begin
        ior(8'h50 + 8'(8 * e + i)); chk(rd, bimg[i]);
      end
    end
    conclude();
  end
endmodule
